// [core/lsi_pkg.sv]
// Shared constants and types for the light sensor serial link
package lsi_pkg;
  // Clock and link rates
  localparam int CLK_HZ = 25000000;
  localparam int STD_HZ = 100000;
  localparam int FAST_HZ = 400000;
  localparam int HSPD_HZ = 2600000;
  // Quarter bit periods, rounded up so no rate is exceeded
  localparam logic [7:0] QTR_STD = 8'((CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ));
  localparam logic [7:0] QTR_FAST = 8'((CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));
  localparam logic [7:0] QTR_HSPD = 8'((CLK_HZ + 4 * HSPD_HZ - 1) / (4 * HSPD_HZ));
  // Sensor register pointers
  localparam logic [7:0] REG_RESULT = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_LOWLIM = 8'h02;
  localparam logic [7:0] REG_HIGHLIM = 8'h03;
  localparam logic [7:0] REG_ID = 8'h7E;
  // Configuration field positions
  localparam int CFG_MODE_LSB = 9;
  localparam int CFG_CRF = 7;
  localparam int CFG_FA = 6;
  localparam int CFG_FB = 5;
  localparam int CFG_LATCH = 4;
  localparam int CFG_POL = 3;
  localparam logic [15:0] CFG_WR_MASK = 16'hFE1F;
  // Reset values
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] LOWLIM_RST = 16'h0000;
  localparam logic [15:0] HIGHLIM_RST = 16'hFFFF;
  // Bus codes
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [6:0] ALERT_ADDR = 7'h0C;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] HS_MCODE = 8'h08;
  localparam logic [1:0] EOC_CODE = 2'h3;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  // Controller register offsets and fields
  localparam logic [11:0] HR_CMD = 12'h000;
  localparam logic [11:0] HR_WDATA = 12'h004;
  localparam logic [11:0] HR_RDATA = 12'h008;
  localparam logic [11:0] HR_STAT = 12'h00C;
  localparam int CMD_NWR_LSB = 8;
  localparam int CMD_FAST = 11;
  localparam int CMD_HSPD = 12;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_INT = 2;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_RX = 3'b010,
    DS_GC = 3'b011,
    DS_ACK = 3'b100,
    DS_TX = 3'b101,
    DS_MACK = 3'b110
  } lsi_dst_e;

  typedef enum logic [2:0] {
    HT_IDLE = 3'b000,
    HT_START = 3'b001,
    HT_BIT = 3'b010,
    HT_STOP = 3'b011,
    HT_RSTRT = 3'b100
  } lsi_hst_e;
endpackage : lsi_pkg

// [core/lsi_if.sv]
// Two-wire link joining controller and sensor ends
`timescale 1ns/1ps
interface lsi_if;
  logic sclLine;
  logic sdaLine;
  logic hostSclOut;
  logic hostSclOe_b;
  logic hostSdaOut;
  logic hostSdaOe_b;
  logic devSclOut;
  logic devSclOe_b;
  logic devSdaOut;
  logic devSdaOe_b;

  // Pulled-up wired-AND of both ends
  assign sclLine = ~((~hostSclOe_b & ~hostSclOut) | (~devSclOe_b & ~devSclOut));
  assign sdaLine = ~((~hostSdaOe_b & ~hostSdaOut) | (~devSdaOe_b & ~devSdaOut));

  modport host (input sclLine, input sdaLine, output hostSclOut, output hostSclOe_b,
    output hostSdaOut, output hostSdaOe_b);
  modport dev (input sclLine, input sdaLine, output devSclOut, output devSclOe_b,
    output devSdaOut, output devSdaOe_b);
endinterface : lsi_if

// [core/lsi_sync.sv]
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module lsi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lsi_sync_s;

  lsi_sync_s r;
  lsi_sync_s n;

  // Shift through both stages
  always_comb begin
    n.s1 = din;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dout = r.s2;
endmodule : lsi_sync

// [core/lsi_dev.sv]
// Sensor end: serial register slave with end-of-conversion interrupt logic
// Summary of operation
// - Low-limit top bits 11b select end-of-conversion mode
// - Every completion sets interrupt and ready flag
// - Latched: read, run write, alert clear interrupt
// - Latched read clears flags; alert keeps flags
// - Latched faults set own flag only
// - Transparent faults set one, clear other
// - Transparent: read/run write clear interrupt; alert ignored
// - Shutdown config write with latch bit set changes nothing
// - Non-shutdown config write clears ready flag
// - Config read clears ready flag afterwards
// - Pin level from state and polarity
// - Leaving mode needs latch bit written zero
// - Standard, fast and high-speed bus rates
// - First written byte loads register pointer
// - Write: address, pointer, two acked data bytes
// - Read sends high byte, then low byte
// - Pointer kept across transactions
// - New read register needs partial write first
// - Master code not acked, high-speed filters on
// - Stop returns filters to standard/fast
// - General call 06h acked, registers reset
// - Transparent mode ignores alert address
// - Alert answer sends address, wins then clears
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module lsi_dev #(
  parameter logic [15:0] ID_VALUE = 16'h5A5A  // Arbitrary identity value
) (
  input wire logic clk,
  input wire logic rst_b,
  lsi_if.dev bus,
  input wire logic [6:0] slaveAddr,
  input wire logic convDone,
  input wire logic aboveHigh,
  input wire logic belowLow,
  input wire logic [15:0] resultWord,
  output logic intPin,
  output logic hsMode,
  output logic [1:0] convMode,
  output logic [15:0] lowLimit,
  output logic [15:0] highLimit
);
  import lsi_pkg::*;

  typedef struct packed {
    lsi_dst_e st;
    lsi_dst_e after;
    logic sclQ;
    logic sdaQ;
    logic [3:0] bitCnt;
    logic [7:0] sh;
    logic [15:0] tx;
    logic ackOn;
    logic ackDo;
    logic sdaLow;
    logic alert;
    logic lsb;
    logic hs;
    logic [7:0] ptr;
    logic [7:0] msb;
    logic [1:0] wrCnt;
    logic [15:0] cfg;
    logic [15:0] lowLim;
    logic [15:0] highLim;
    logic flagAbove;
    logic flagBelow;
    logic crf;
    logic intAct;
    logic intPin;
  } lsi_dev_s;

  lsi_dev_s r;
  lsi_dev_s n;
  logic [8:0] syncOut;
  logic [6:0] addrS;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic eocMode;
  logic latchMode;
  logic [7:0] inByte;
  logic [15:0] cfgView;
  logic [15:0] rdWord;
  logic cfgRd;
  logic cfgWr;
  logic [15:0] wrVal;
  logic alertWon;
  logic gcRst;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection
  lsi_sync #(.W(9)) uSync (
    .clk(clk),
    .rst_b(rst_b),
    .din({slaveAddr, bus.sclLine, bus.sdaLine}),
    .dout(syncOut)
  );

  assign addrS = syncOut[8:2];
  assign sclS = syncOut[1];
  assign sdaS = syncOut[0];
  assign sclRise = sclS & ~r.sclQ;
  assign sclFall = ~sclS & r.sclQ;
  assign startCond = r.sclQ & sclS & r.sdaQ & ~sdaS;
  assign stopCond = r.sclQ & sclS & ~r.sdaQ & sdaS;
  assign eocMode = (r.lowLim[15:14] == EOC_CODE);
  assign latchMode = r.cfg[CFG_LATCH];
  assign inByte = {r.sh[6:0], sdaS};
  assign cfgView = {r.cfg[15:9], 1'b0, r.crf, r.flagAbove, r.flagBelow, r.cfg[4:0]};

  // Register read mux
  always_comb begin
    case (r.ptr)
      REG_RESULT: rdWord = resultWord;
      REG_CFG: rdWord = cfgView;
      REG_LOWLIM: rdWord = r.lowLim;
      REG_HIGHLIM: rdWord = r.highLim;
      REG_ID: rdWord = ID_VALUE;
      default: rdWord = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol engine and interrupt state
  always_comb begin
    n = r;
    cfgRd = 1'b0;
    cfgWr = 1'b0;
    wrVal = {r.msb, inByte};
    alertWon = 1'b0;
    gcRst = 1'b0;
    n.sclQ = sclS;
    n.sdaQ = sdaS;
    case (r.st)
      DS_IDLE: begin
        n.sdaLow = 1'b0;
      end
      DS_ADDR, DS_RX, DS_GC: begin
        if (sclRise) begin
          n.sh = inByte;
          n.bitCnt = r.bitCnt + 4'h1;
          if (r.bitCnt == 4'h7) begin
            n.st = DS_ACK;
            n.ackDo = 1'b0;
            n.after = DS_IDLE;
            n.bitCnt = 4'h0;
            if (r.st == DS_ADDR) begin
              if (inByte[7:1] == addrS) begin
                n.ackDo = 1'b1;
                n.alert = 1'b0;
                n.lsb = 1'b0;
                n.wrCnt = 2'h0;
                if (inByte[0]) begin
                  n.tx = rdWord;
                  cfgRd = (r.ptr == REG_CFG);
                  n.after = DS_TX;
                end else begin
                  n.after = DS_RX;
                end
              end else if (inByte == {GC_ADDR, 1'b0}) begin
                n.ackDo = 1'b1;
                n.after = DS_GC;
              end else if (inByte == {ALERT_ADDR, 1'b1} && latchMode && r.intAct) begin
                n.ackDo = 1'b1;
                n.alert = 1'b1;
                n.lsb = 1'b1;
                n.tx = {addrS, r.flagAbove, 8'h00};
                n.after = DS_TX;
              end else if (inByte[7:3] == HS_CODE_TOP) begin
                n.hs = 1'b1;
              end
            end else if (r.st == DS_GC) begin
              if (inByte == GC_RESET) begin
                n.ackDo = 1'b1;
                gcRst = 1'b1;
              end
            end else begin
              n.ackDo = 1'b1;
              n.after = DS_RX;
              if (r.wrCnt != 2'h3) begin
                n.wrCnt = r.wrCnt + 2'h1;
              end
              case (r.wrCnt)
                2'h0: n.ptr = inByte;
                2'h1: n.msb = inByte;
                2'h2: begin
                  case (r.ptr)
                    REG_CFG: begin
                      n.cfg = (wrVal & CFG_WR_MASK) | (r.cfg & ~CFG_WR_MASK);
                      cfgWr = 1'b1;
                    end
                    REG_LOWLIM: n.lowLim = wrVal;
                    REG_HIGHLIM: n.highLim = wrVal;
                    default: n.msb = r.msb;
                  endcase
                end
                default: n.msb = r.msb;
              endcase
            end
          end
        end
      end
      DS_ACK: begin
        if (sclFall) begin
          if (!r.ackOn) begin
            n.ackOn = 1'b1;
            n.sdaLow = r.ackDo;
          end else begin
            n.ackOn = 1'b0;
            n.st = r.after;
            n.sdaLow = (r.after == DS_TX) ? ~r.tx[15] : 1'b0;
          end
        end
      end
      DS_TX: begin
        if (sclRise) begin
          n.bitCnt = r.bitCnt + 4'h1;
          n.tx = {r.tx[14:0], 1'b0};
          if (!r.sdaLow && !sdaS) begin
            n.st = DS_IDLE;  // Lost arbitration, interrupt stays
          end
        end else if (sclFall) begin
          if (r.bitCnt == 4'h8) begin
            n.sdaLow = 1'b0;
            n.st = DS_MACK;
            alertWon = r.alert;
          end else begin
            n.sdaLow = ~r.tx[15];
          end
        end
      end
      DS_MACK: begin
        if (sclRise) begin
          n.bitCnt = 4'h0;
          if (!sdaS && !r.lsb) begin
            n.lsb = 1'b1;
            n.st = DS_TX;
          end else begin
            n.st = DS_IDLE;
          end
        end
      end
      default: n.st = DS_IDLE;
    endcase
    if (stopCond) begin
      n.st = DS_IDLE;
      n.hs = 1'b0;
      n.sdaLow = 1'b0;
      n.ackOn = 1'b0;
    end
    if (startCond) begin
      n.st = DS_ADDR;
      n.bitCnt = 4'h0;
      n.sdaLow = 1'b0;
      n.ackOn = 1'b0;
    end
    // Read, write and alert clears first, so a completion in the same cycle wins; general-call reset last, so it wins
    if (cfgRd) begin
      n.crf = 1'b0;
      if (latchMode) begin
        n.flagAbove = 1'b0;
        n.flagBelow = 1'b0;
        n.intAct = 1'b0;
      end else if (eocMode) begin
        n.intAct = 1'b0;
      end
    end
    if (cfgWr) begin
      if (wrVal[CFG_MODE_LSB +: 2] != MODE_SHUTDOWN) begin
        n.crf = 1'b0;
        if (eocMode) begin
          n.intAct = 1'b0;
        end
      end
      if (!wrVal[CFG_LATCH]) begin
        n.intAct = 1'b0;
      end
    end
    if (alertWon) begin
      n.intAct = 1'b0;
    end
    // Conversion completion from the measurement core
    if (convDone) begin
      n.crf = 1'b1;
      if (aboveHigh) begin
        n.flagAbove = 1'b1;
        if (!latchMode) begin
          n.flagBelow = 1'b0;
        end
      end
      if (belowLow) begin
        n.flagBelow = 1'b1;
        if (!latchMode) begin
          n.flagAbove = 1'b0;
        end
      end
      if (eocMode) begin
        n.intAct = 1'b1;
      end else if (aboveHigh) begin
        n.intAct = 1'b1;
      end else if (belowLow) begin
        n.intAct = latchMode;
      end
    end
    if (gcRst) begin
      n.cfg = CFG_RST;
      n.lowLim = LOWLIM_RST;
      n.highLim = HIGHLIM_RST;
      n.ptr = REG_RESULT;
      n.flagAbove = 1'b0;
      n.flagBelow = 1'b0;
      n.crf = 1'b0;
      n.intAct = 1'b0;
    end
    n.intPin = ~(n.intAct ^ n.cfg[CFG_POL]);
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{st: DS_IDLE, after: DS_IDLE, sclQ: 1'b1, sdaQ: 1'b1, cfg: CFG_RST,
        lowLim: LOWLIM_RST, highLim: HIGHLIM_RST, intPin: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe_b = ~r.sdaLow;
  assign bus.devSclOut = 1'b0;
  assign bus.devSclOe_b = 1'b1;  // Never stretches the clock
  assign intPin = r.intPin;
  assign hsMode = r.hs;
  assign convMode = r.cfg[CFG_MODE_LSB +: 2];
  assign lowLimit = r.lowLim;
  assign highLimit = r.highLim;
endmodule : lsi_dev

// [core/lsi_host.sv]
// Controller end: APB-driven bus master for the sensor link
`timescale 1ns/1ps
module lsi_host (
  input wire logic clk,
  input wire logic rst_b,
  lsi_if.host bus,
  input wire logic devInt,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import lsi_pkg::*;

  typedef struct packed {
    lsi_hst_e st;
    logic [7:0] qCnt;
    logic [1:0] ph;
    logic [3:0] bitIdx;
    logic [7:0] sh;
    logic [1:0] byteNo;
    logic [1:0] nWr;
    logic rd;
    logic hsPend;
    logic hsOn;
    logic fast;
    logic [7:0] addrB;
    logic [23:0] wdata;
    logic [15:0] rdata;
    logic nack;
    logic busy;
    logic scl;
    logic sda;
    logic [31:0] prdata;
  } lsi_host_s;

  lsi_host_s r;
  lsi_host_s n;
  logic [1:0] syncOut;
  logic sdaS;
  logic intS;
  logic tick;
  logic txByte;
  logic mapped;
  logic [7:0] qtr;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and APB decode
  lsi_sync #(.W(2)) uSync (
    .clk(clk),
    .rst_b(rst_b),
    .din({devInt, bus.sdaLine}),
    .dout(syncOut)
  );

  assign intS = syncOut[1];
  assign sdaS = syncOut[0];
  assign mapped = (paddr == HR_CMD) || (paddr == HR_WDATA) || (paddr == HR_RDATA)
    || (paddr == HR_STAT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign tick = (r.qCnt == 8'h00);
  assign txByte = (r.byteNo == 2'h0) || !r.rd;
  assign qtr = r.hsOn ? QTR_HSPD : (r.fast ? QTR_FAST : QTR_STD);

  ////////////////////////////////////////////////////////////////////////////////
  // Register access and bit engine
  always_comb begin
    n = r;
    // Read data registered in the setup cycle
    if (psel && !penable) begin
      case (paddr)
        HR_WDATA: n.prdata = {8'h00, r.wdata};
        HR_RDATA: n.prdata = {16'h0000, r.rdata};
        HR_STAT: n.prdata = {29'h0, intS, r.nack, r.busy};
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite) begin
      if (paddr == HR_WDATA) begin
        n.wdata = pwdata[23:0];
      end else if (paddr == HR_CMD && !r.busy) begin
        n.addrB = pwdata[7:0];
        n.rd = pwdata[0];
        n.nWr = pwdata[CMD_NWR_LSB +: 2];
        n.fast = pwdata[CMD_FAST];
        n.hsPend = pwdata[CMD_HSPD];
        n.busy = 1'b1;
        n.nack = 1'b0;
        n.st = HT_START;
        n.ph = 2'h0;
        n.qCnt = 8'h00;
      end
    end
    if (r.st != HT_IDLE) begin
      n.qCnt = tick ? qtr : r.qCnt - 8'h01;
    end
    if (tick) begin
      n.ph = r.ph + 2'h1;
      case (r.st)
        HT_IDLE: begin
          n.ph = 2'h0;
        end
        HT_START: begin
          n.bitIdx = 4'h0;
          n.byteNo = 2'h0;
          case (r.ph)
            2'h0: begin
              n.sda = 1'b1;
              n.scl = 1'b1;
            end
            2'h1: n.sda = 1'b0;
            2'h2: n.scl = 1'b0;
            default: begin
              n.sh = r.hsPend ? HS_MCODE : r.addrB;
              n.st = HT_BIT;
            end
          endcase
        end
        HT_RSTRT: begin
          case (r.ph)
            2'h0: n.sda = 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda = 1'b0;
            default: begin
              n.scl = 1'b0;
              n.hsOn = 1'b1;
              n.byteNo = 2'h0;  // Master code byte not counted
              n.sh = r.addrB;
              n.st = HT_BIT;
            end
          endcase
        end
        HT_BIT: begin
          case (r.ph)
            2'h0: begin
              if (r.bitIdx != 4'h8) begin
                n.sda = txByte ? r.sh[7] : 1'b1;
              end else begin
                n.sda = txByte ? 1'b1 : (r.byteNo != 2'h1);
              end
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.bitIdx != 4'h8 && !txByte) begin
                n.sh = {r.sh[6:0], sdaS};
              end else if (r.bitIdx == 4'h8 && txByte) begin
                n.nack = sdaS & ~r.hsPend;
              end
            end
            default: begin
              n.scl = 1'b0;
              n.bitIdx = r.bitIdx + 4'h1;
              if (r.bitIdx != 4'h8 && txByte) begin
                n.sh = {r.sh[6:0], 1'b0};
              end
              if (r.bitIdx == 4'h8) begin
                n.bitIdx = 4'h0;
                n.byteNo = r.byteNo + 2'h1;
                if (r.hsPend) begin
                  n.hsPend = 1'b0;
                  n.st = HT_RSTRT;
                end else if (txByte && n.nack) begin
                  n.st = HT_STOP;
                end else if (r.rd) begin
                  if (r.byteNo == 2'h1) begin
                    n.rdata[15:8] = r.sh;
                  end else if (r.byteNo == 2'h2) begin
                    n.rdata[7:0] = r.sh;
                    n.st = HT_STOP;
                  end
                end else if (r.byteNo == r.nWr) begin
                  n.st = HT_STOP;
                end else begin
                  // Pointer then high and low data bytes
                  case (r.byteNo)
                    2'h0: n.sh = r.wdata[23:16];
                    2'h1: n.sh = r.wdata[15:8];
                    default: n.sh = r.wdata[7:0];
                  endcase
                end
              end
            end
          endcase
        end
        HT_STOP: begin
          case (r.ph)
            2'h0: n.sda = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda = 1'b1;
            default: begin
              n.hsOn = 1'b0;
              n.busy = 1'b0;
              n.st = HT_IDLE;
            end
          endcase
        end
        default: n.st = HT_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{st: HT_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSclOe_b = r.scl;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOe_b = r.sda;
  assign prdata = r.prdata;
endmodule : lsi_host

// [tb/lsi_props.sv]
// Link framing and interrupt timing properties
`timescale 1ns/1ps
module lsi_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclLine,
  input wire logic sdaLine,
  input wire logic hostSdaOe_b,
  input wire logic devSclOe_b,
  input wire logic devSdaOe_b,
  input wire logic convDone,
  input wire logic intPin,
  input wire logic hsMode,
  input wire logic [15:0] lowLimit
);
  // Single clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////
  // Stop condition and clock low phase
  sequence stopSeen;
    $rose(sdaLine) && sclLine;
  endsequence
  sequence lowPhase;
    !sclLine [*4];
  endsequence
  ////////////////////////////////
  // Bench keeps interrupt polarity at 0
  line_rel_a: assert property ($rose(rst_b) |-> hostSdaOe_b && devSdaOe_b && intPin)
    else $error("line held or pin active after reset");
  no_stretch_a: assert property (devSclOe_b)
    else $error("sensor pulled the clock line");
  clk_low_a: assert property ($fell(sclLine) |-> lowPhase)
    else $error("clock low phase too short");
  host_start_a: assert property ($fell(sdaLine) && sclLine |-> !hostSdaOe_b)
    else $error("start not made by controller");
  dev_drive_a: assert property ($fell(devSdaOe_b) |-> !sclLine)
    else $error("sensor drove data with clock high");
  eoc_int_a: assert property (convDone && lowLimit[15:14] == 2'h3 |=> ##[0:1] !intPin)
    else $error("no interrupt after completion");
  int_src_a: assert property ($fell(intPin) |-> $past(convDone) || $past(convDone,2))
    else $error("interrupt without completion");
  hs_end_a: assert property (stopSeen |-> ##[1:8] !hsMode)
    else $error("filters not restored after stop");
endmodule : lsi_props

// [tb/test_light_sensor_i2c_slave_eoc_irq.sv]
// Bench joining controller and sensor ends over the two-wire link
`timescale 1ns/1ps
module test_light_sensor_i2c_slave_eoc_irq;
  import lsi_pkg::*;
  localparam logic [6:0] SA = 7'h44;
  localparam logic [31:0] FW = 32'h1 << CMD_FAST;
  localparam logic [31:0] ALERT = FW | {24'h0, ALERT_ADDR, 1'b1};
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic convDone = 1'b0, aboveHigh = 1'b0, belowLow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] resultWord = 16'h1234;
  logic pready, pslverr, err, intPin, hsMode;
  logic [1:0] convMode;
  logic [31:0] prdata, rdv;
  logic [15:0] lowLimit, highLimit;
  int fails = 0;
  int checks = 0;
  lsi_if bus();
  lsi_host lsi_host_inst (.clk, .rst_b, .bus, .devInt(intPin), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  lsi_dev lsi_dev_inst (.clk, .rst_b, .bus, .slaveAddr(SA), .convDone, .aboveHigh,
    .belowLow, .resultWord, .intPin, .hsMode, .convMode, .lowLimit, .highLimit);
  lsi_props lsi_props_inst (.clk, .rst_b, .sclLine(bus.sclLine), .sdaLine(bus.sdaLine),
    .hostSdaOe_b(bus.hostSdaOe_b), .devSclOe_b(bus.devSclOe_b),
    .devSdaOe_b(bus.devSdaOe_b), .convDone, .intPin, .hsMode, .lowLimit);
  ////////////////////////////////
  // Clock and bench services
  always #20 clk = ~clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: saw %h, want %h", $time, s, e);
    end
  endtask : chk
  task end_sim();
    $display("checks %0d, fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task hang();
    chk(1'b0, 1'b1);
    end_sim();
  endtask : hang
  // APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) hang();
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Link transfer: data word, command, then poll until idle
  task xfer(input logic [31:0] cmd, input logic [31:0] wd);
    int n;
    apb(1'b1, HR_WDATA, wd);
    apb(1'b1, HR_CMD, cmd);
    n = 0;
    do begin
      apb(1'b0, HR_STAT, 32'h0);
      n++;
    end while (rdv[STAT_BUSY] !== 1'b0 && n < 4000);
    if (rdv[STAT_BUSY] !== 1'b0) hang();
  endtask : xfer
  // Fast-rate command for the sensor address
  function automatic logic [31:0] ab(input logic [1:0] nb, input logic r);
    return FW | {22'h0, nb, SA, r};
  endfunction : ab
  task wreg(input logic [7:0] p, input logic [15:0] v);
    xfer(ab(2'h3, 1'b0), {8'h00, p, v});
  endtask : wreg
  task rd();
    xfer(ab(2'h0, 1'b1), 32'h0);
    apb(1'b0, HR_RDATA, 32'h0);
  endtask : rd
  // One completion pulse with its fault results
  task pulse(input logic ah, input logic bl);
    @(posedge clk);
    convDone <= 1'b1;
    aboveHigh <= ah;
    belowLow <= bl;
    @(posedge clk);
    convDone <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  ////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    chk(rdv, 32'h0);
    wreg(REG_HIGHLIM, 16'hA5C3);
    chk(highLimit, 16'hA5C3);
    rd();
    chk(rdv[15:0], 16'hA5C3);
    rd();
    chk(rdv[15:0], 16'hA5C3);
    $display("done: access");
    wreg(REG_LOWLIM, 16'hC000);
    chk(lowLimit, 16'hC000);
    wreg(REG_CFG, 16'h0410);
    chk(convMode, 2'h2);
    pulse(1'b1, 1'b0);
    chk(intPin, 1'b0);
    apb(1'b0, HR_STAT, 32'h0);
    chk(rdv[STAT_INT], 1'b0);
    rd();
    chk(rdv[15:0], 16'h04D0);
    chk(intPin, 1'b1);
    rd();
    chk(rdv[15:0], 16'h0410);
    pulse(1'b0, 1'b0);
    chk(intPin, 1'b0);
    wreg(REG_CFG, 16'h0412);
    chk(intPin, 1'b1);
    rd();
    chk(rdv[15:0], 16'h0412);
    $display("done: latched");
    pulse(1'b1, 1'b0);
    xfer(ALERT, 32'h0);
    apb(1'b0, HR_RDATA, 32'h0);
    chk(rdv[15:8], {SA, 1'b1});
    chk(intPin, 1'b1);
    rd();
    chk(rdv[15:0], 16'h04D2);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    wreg(REG_CFG, 16'h0010);
    chk(intPin, 1'b0);
    rd();
    chk(rdv[15:0], 16'h00F0);
    // Leave end-of-conversion mode with latch set, then clear via latch bit
    pulse(1'b1, 1'b0);
    wreg(REG_LOWLIM, 16'h0000);
    chk(intPin, 1'b0);
    wreg(REG_CFG, 16'h0000);
    chk(intPin, 1'b1);
    wreg(REG_LOWLIM, 16'hC000);
    $display("done: alert and shutdown");
    wreg(REG_CFG, 16'h0400);
    pulse(1'b1, 1'b0);
    xfer(ALERT, 32'h0);
    chk(rdv[STAT_NACK], 1'b1);
    chk(intPin, 1'b0);
    pulse(1'b0, 1'b1);
    chk(intPin, 1'b0);
    rd();
    chk(rdv[15:0], 16'h04A0);
    chk(intPin, 1'b1);
    xfer((32'h1 << CMD_HSPD) | ab(2'h3, 1'b0), {8'h00, REG_HIGHLIM, 16'h0F0F});
    chk(highLimit, 16'h0F0F);
    xfer({22'h0, 2'h1, GC_ADDR, 1'b0}, {8'h00, GC_RESET, 16'h0000});
    chk(hsMode, 1'b0);
    chk(lowLimit, LOWLIM_RST);
    chk(highLimit, HIGHLIM_RST);
    chk(convMode, 2'h0);
    // Pointer-only write, then read the new register
    xfer(ab(2'h1, 1'b0), {8'h00, REG_HIGHLIM, 16'h0000});
    rd();
    chk(rdv[15:0], HIGHLIM_RST);
    $display("done: transparent, high speed, reset");
    end_sim();
  end
endmodule : test_light_sensor_i2c_slave_eoc_irq
